// ===== hdl/hwa_pkg.sv
package hwa_pkg;

    localparam int HALF_W = 16;
    localparam int REG_COUNT = 16;

    // register byte offsets
    localparam logic [4:0] ADDR_CMD = 5'h00;
    localparam logic [4:0] ADDR_AFIELD = 5'h04;
    localparam logic [4:0] ADDR_PROG_STATUS = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_GPR_SEL = 5'h10;
    localparam logic [4:0] ADDR_GPR_DATA = 5'h14;

    // field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_FIRST_REG_LSB = 4;
    localparam int CMD_F2_LSB = 8;
    localparam int CMD_GO_BIT = 31;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;

    // reset values
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [15:0] AFIELD_RESET = 16'h0000;
    localparam logic [3:0] COND_CODE_RESET = 4'h0;
    localparam logic [3:0] GPR_SEL_RESET = 4'h0;

    // store-multiple stepping
    localparam logic [15:0] HALF_STEP = 16'h0002;
    localparam logic [3:0] LAST_REG = 4'hf;

    typedef enum logic [2:0] {
        OP_ADD_SHORT_IMMEDIATE = 3'h0,
        OP_ADD_REG_REG = 3'h1,
        OP_ADD_MEM_OPERAND = 3'h2,
        OP_ADD_ADDRESS_IMMEDIATE = 3'h3,
        OP_ADD_TO_MEMORY = 3'h4,
        OP_ADD_CARRY_REG_REG = 3'h5,
        OP_ADD_CARRY_MEM_OPERAND = 3'h6,
        OP_STORE_MULTIPLE_REGS = 3'h7
    } hwa_op_type;

    // condition code, program status bits 3..0 in that order
    typedef struct packed {
        logic carry;
        logic overflow;
        logic greater;
        logic less;
    } hwa_cond_code_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic chk;
        logic [15:0] addr;
        logic [15:0] wdata;
    } hwa_mem_cmd_type;

    typedef struct packed {
        logic ack;
        logic chk_ack;
        logic chk_deny;
        logic [15:0] rdata;
    } hwa_mem_rsp_type;

endpackage : hwa_pkg

// ===== hdl/hwa_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module hwa_regfile #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // clock
    input wire logic rst, // synchronous reset
    input wire logic we, // write strobe
    input wire logic [$clog2(DEPTH)-1:0] waddr, // write index
    input wire logic [WIDTH-1:0] wdata, // write data
    input wire logic [$clog2(DEPTH)-1:0] raddr, // read index
    output logic [WIDTH-1:0] rdata // registered read data
);

    logic [WIDTH-1:0] mem [DEPTH];

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
            $error("hwa_regfile: DEPTH must be at least 2 and WIDTH at least 1");
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : hwa_regfile
`default_nettype wire

// ===== hdl/hwa_adder.sv
`timescale 1ns/1ps
`default_nettype none
module hwa_adder (
    input wire logic [15:0] addend_a, // first operand
    input wire logic [15:0] addend_b, // second operand
    input wire logic carry_in, // carry bit taken into the sum
    input wire logic chain, // add-with-carry in progress
    input wire logic prev_nonzero, // earlier parts of the chain were nonzero
    output logic [15:0] sum, // halfword sum
    output var hwa_pkg::hwa_cond_code_type cond_code // resulting condition code
);

    logic [16:0] wide;
    logic sum_zero;
    logic whole_zero;

    assign wide = {1'b0, addend_a} + {1'b0, addend_b} + {16'h0000, carry_in};
    assign sum = wide[15:0];
    assign sum_zero = (sum == 16'h0000);
    // zero only if every part of a chain is zero
    assign whole_zero = sum_zero & ~(chain & prev_nonzero);

    assign cond_code.carry = wide[16];
    assign cond_code.overflow = (addend_a[15] == addend_b[15])
        & (sum[15] != addend_a[15]);
    assign cond_code.greater = ~sum[15] & ~whole_zero;
    assign cond_code.less = sum[15];

endmodule : hwa_adder
`default_nettype wire

// ===== hdl/hwa_add_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module hwa_add_datapath (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output var hwa_pkg::hwa_mem_cmd_type mem_cmd, // core memory and protect request
    input wire hwa_pkg::hwa_mem_rsp_type mem_rsp, // core memory and protect answer
    output logic busy // command in progress
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_R1,
        ST_RD_F2,
        ST_CAP_F2,
        ST_MEM_RD,
        ST_ADD,
        ST_WB,
        ST_SM_RD,
        ST_SM_CAP,
        ST_PROT,
        ST_MEM_WR
    } hwa_state_type;

    hwa_state_type state;
    hwa_state_type next_state;
    hwa_pkg::hwa_op_type op;
    hwa_pkg::hwa_op_type next_op;
    logic [3:0] first_register_field;
    logic [3:0] next_first_register_field;
    logic [3:0] second_field;
    logic [3:0] next_second_field;
    logic [3:0] cur;
    logic [3:0] next_cur;
    logic [15:0] op1;
    logic [15:0] next_op1;
    logic [15:0] op2;
    logic [15:0] next_op2;
    logic [15:0] sum_q;
    logic [15:0] next_sum;
    hwa_pkg::hwa_cond_code_type condition_code;
    hwa_pkg::hwa_cond_code_type next_condition_code;
    hwa_pkg::hwa_mem_cmd_type next_mem_cmd;
    logic fault;
    logic next_fault;
    logic fault_set;
    logic next_busy;

    logic [31:0] cmd_shadow;
    logic [15:0] afield;
    logic [3:0] gpr_sel;
    logic bus_stage;

    logic [3:0] rf_raddr;
    logic [15:0] rf_rdata;
    logic rf_we;
    logic [3:0] rf_waddr;
    logic [15:0] rf_wdata;

    logic [15:0] add_sum;
    hwa_pkg::hwa_cond_code_type add_cond_code;

    function automatic logic [31:0] merge_word(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] lanes
    );
        logic [31:0] mask;
        mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
        merge_word = (old_word & ~mask) | (new_word & mask);
    endfunction : merge_word

    // bus decode
    wire logic bus_req = avs_read | avs_write;
    wire logic bus_fire = bus_req & ~avs_waitrequest;
    wire logic wr_fire = bus_fire & avs_write;
    wire logic rd_load = bus_req & avs_waitrequest & bus_stage & avs_read;
    wire logic sel_cmd = (avs_address == hwa_pkg::ADDR_CMD);
    wire logic sel_afield = (avs_address == hwa_pkg::ADDR_AFIELD);
    wire logic sel_prog_status = (avs_address == hwa_pkg::ADDR_PROG_STATUS);
    wire logic sel_status = (avs_address == hwa_pkg::ADDR_STATUS);
    wire logic sel_gsel = (avs_address == hwa_pkg::ADDR_GPR_SEL);
    wire logic sel_gdata = (avs_address == hwa_pkg::ADDR_GPR_DATA);

    wire logic [31:0] cmd_merged = merge_word(cmd_shadow, avs_writedata, avs_byteenable);
    wire logic [31:0] afield_merged = merge_word({16'h0000, afield}, avs_writedata,
        avs_byteenable);
    wire logic [31:0] prog_status_merged = merge_word({28'h0000000, condition_code},
        avs_writedata, avs_byteenable);
    wire logic [31:0] status_merged = avs_writedata & {{8{avs_byteenable[3]}},
        {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic [31:0] gsel_merged = merge_word({28'h0000000, gpr_sel}, avs_writedata,
        avs_byteenable);
    wire logic [31:0] gdata_merged = merge_word({16'h0000, rf_rdata}, avs_writedata,
        avs_byteenable);

    wire logic start = wr_fire & sel_cmd & cmd_merged[hwa_pkg::CMD_GO_BIT] & ~busy;
    wire logic prog_status_wr = wr_fire & sel_prog_status & ~busy;
    wire logic gdata_wr = wr_fire & sel_gdata & ~busy;
    wire logic fault_clr = wr_fire & sel_status & status_merged[hwa_pkg::STAT_FAULT_BIT];

    wire logic [31:0] status_word = ({31'h00000000, busy} << hwa_pkg::STAT_BUSY_BIT)
        | ({31'h00000000, fault} << hwa_pkg::STAT_FAULT_BIT);
    wire logic [31:0] rd_mux = sel_cmd ? cmd_shadow
        : sel_afield ? {16'h0000, afield}
        : sel_prog_status ? {28'h0000000, condition_code}
        : sel_status ? status_word
        : sel_gsel ? {28'h0000000, gpr_sel}
        : sel_gdata ? {16'h0000, (busy ? 16'h0000 : rf_rdata)}
        : 32'h00000000;

    // datapath decode
    wire logic carry_op = (op == hwa_pkg::OP_ADD_CARRY_REG_REG)
        | (op == hwa_pkg::OP_ADD_CARRY_MEM_OPERAND);
    wire logic [15:0] eff_addr = afield + rf_rdata;
    wire logic last_store = (cur == hwa_pkg::LAST_REG);

    assign rf_raddr = (state == ST_RD_R1) ? first_register_field
        : (state == ST_RD_F2) ? second_field
        : (state == ST_SM_RD) ? cur
        : gpr_sel;
    assign rf_we = (state == ST_WB) | gdata_wr;
    assign rf_waddr = (state == ST_WB) ? first_register_field : gpr_sel;
    assign rf_wdata = (state == ST_WB) ? sum_q : gdata_merged[15:0];

    hwa_regfile #(
        .WIDTH(hwa_pkg::HALF_W),
        .DEPTH(hwa_pkg::REG_COUNT)
    ) u_regfile (
        .sys_clk(sys_clk),
        .rst(rst),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr(rf_raddr),
        .rdata(rf_rdata)
    );

    hwa_adder u_adder (
        .addend_a(op1),
        .addend_b(op2),
        .carry_in(carry_op & condition_code.carry),
        .chain(carry_op),
        .prev_nonzero(condition_code.greater | condition_code.less),
        .sum(add_sum),
        .cond_code(add_cond_code)
    );

    always_comb begin
        next_state = state;
        next_op = op;
        next_first_register_field = first_register_field;
        next_second_field = second_field;
        next_cur = cur;
        next_op1 = op1;
        next_op2 = op2;
        next_sum = sum_q;
        next_condition_code = condition_code;
        next_mem_cmd = mem_cmd;
        fault_set = 1'b0;
        if (prog_status_wr) begin
            next_condition_code =
                hwa_pkg::hwa_cond_code_type'(prog_status_merged[3:0]);
        end
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_op = hwa_pkg::hwa_op_type'(cmd_merged[hwa_pkg::CMD_OP_LSB +: 3]);
                    next_first_register_field = cmd_merged[hwa_pkg::CMD_FIRST_REG_LSB +: 4];
                    next_second_field = cmd_merged[hwa_pkg::CMD_F2_LSB +: 4];
                    next_state = ST_RD_R1;
                end
            end
            ST_RD_R1: begin
                next_state = ST_RD_F2;
            end
            ST_RD_F2: begin
                next_op1 = rf_rdata;
                next_state = ST_CAP_F2;
            end
            ST_CAP_F2: begin
                next_mem_cmd.addr = eff_addr;
                unique case (op)
                    hwa_pkg::OP_ADD_SHORT_IMMEDIATE: begin
                        next_op2 = {12'h000, second_field};
                        next_state = ST_ADD;
                    end
                    hwa_pkg::OP_ADD_REG_REG, hwa_pkg::OP_ADD_CARRY_REG_REG: begin
                        next_op2 = rf_rdata;
                        next_state = ST_ADD;
                    end
                    hwa_pkg::OP_ADD_ADDRESS_IMMEDIATE: begin
                        next_op2 = eff_addr;
                        next_state = ST_ADD;
                    end
                    hwa_pkg::OP_ADD_MEM_OPERAND, hwa_pkg::OP_ADD_CARRY_MEM_OPERAND,
                    hwa_pkg::OP_ADD_TO_MEMORY: begin
                        next_mem_cmd.rd = 1'b1;
                        next_state = ST_MEM_RD;
                    end
                    hwa_pkg::OP_STORE_MULTIPLE_REGS: begin
                        next_cur = first_register_field;
                        next_state = ST_SM_RD;
                    end
                endcase
            end
            ST_MEM_RD: begin
                if (mem_rsp.ack) begin
                    next_mem_cmd.rd = 1'b0;
                    next_op2 = mem_rsp.rdata;
                    next_state = ST_ADD;
                end
            end
            ST_ADD: begin
                next_sum = add_sum;
                next_condition_code = add_cond_code;
                if (op == hwa_pkg::OP_ADD_TO_MEMORY) begin
                    // first register is left untouched
                    next_mem_cmd.wdata = add_sum;
                    next_mem_cmd.chk = 1'b1;
                    next_state = ST_PROT;
                end else begin
                    next_state = ST_WB;
                end
            end
            ST_WB: begin
                next_state = ST_IDLE;
            end
            ST_SM_RD: begin
                next_state = ST_SM_CAP;
            end
            ST_SM_CAP: begin
                next_mem_cmd.wdata = rf_rdata;
                next_mem_cmd.chk = 1'b1;
                next_state = ST_PROT;
            end
            ST_PROT: begin
                if (mem_rsp.chk_ack) begin
                    next_mem_cmd.chk = 1'b0;
                    if (mem_rsp.chk_deny) begin
                        // refused store aborts the rest of the command
                        fault_set = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_mem_cmd.wr = 1'b1;
                        next_state = ST_MEM_WR;
                    end
                end
            end
            ST_MEM_WR: begin
                if (mem_rsp.ack) begin
                    next_mem_cmd.wr = 1'b0;
                    if (op == hwa_pkg::OP_STORE_MULTIPLE_REGS && !last_store) begin
                        next_cur = cur + 4'h1;
                        next_mem_cmd.addr = mem_cmd.addr + hwa_pkg::HALF_STEP;
                        next_state = ST_SM_RD;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign next_busy = (next_state != ST_IDLE);
    // a new refusal wins over a clear in the same cycle
    assign next_fault = fault_set | (fault & ~fault_clr);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            fault <= 1'b0;
            condition_code <= hwa_pkg::hwa_cond_code_type'(hwa_pkg::COND_CODE_RESET);
            mem_cmd <= '0;
        end else begin
            state <= next_state;
            busy <= next_busy;
            fault <= next_fault;
            condition_code <= next_condition_code;
            mem_cmd <= next_mem_cmd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op <= hwa_pkg::OP_ADD_SHORT_IMMEDIATE;
            first_register_field <= 4'h0;
            second_field <= 4'h0;
            cur <= 4'h0;
        end else begin
            op <= next_op;
            first_register_field <= next_first_register_field;
            second_field <= next_second_field;
            cur <= next_cur;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op1 <= 16'h0000;
            op2 <= 16'h0000;
            sum_q <= 16'h0000;
        end else begin
            op1 <= next_op1;
            op2 <= next_op2;
            sum_q <= next_sum;
        end
    end

    // two wait cycles give the register file read time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_stage <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            bus_stage <= bus_req & avs_waitrequest;
            avs_waitrequest <= ~(bus_req & avs_waitrequest & bus_stage);
            if (rd_load) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_shadow <= hwa_pkg::CMD_RESET;
            afield <= hwa_pkg::AFIELD_RESET;
            gpr_sel <= hwa_pkg::GPR_SEL_RESET;
        end else begin
            if (start) begin
                cmd_shadow <= cmd_merged & ~(32'h00000001 << hwa_pkg::CMD_GO_BIT);
            end
            if (wr_fire && sel_afield && !busy) begin
                afield <= afield_merged[15:0];
            end
            if (wr_fire && sel_gsel) begin
                gpr_sel <= gsel_merged[3:0];
            end
        end
    end

endmodule : hwa_add_datapath
`default_nettype wire

// ===== test/hwa_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hwa_assertions (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic avs_waitrequest, // stall
    input wire hwa_pkg::hwa_mem_cmd_type mem_cmd, // memory request
    input wire hwa_pkg::hwa_mem_rsp_type mem_rsp, // memory answer
    input wire logic busy // command running
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic prev_req, prev_done, ok_vld, wrote;
    logic [15:0] ok_addr, last_wr;
    wire req = avs_read | avs_write;
    wire start = req & (~prev_req | prev_done);
    wire wr_done = mem_cmd.wr & mem_rsp.ack;
    wire chk_ok = mem_cmd.chk & mem_rsp.chk_ack & ~mem_rsp.chk_deny;
    always_ff @(posedge sys_clk) begin
        prev_req <= req & ~rst;
        prev_done <= req & ~avs_waitrequest;
        ok_vld <= ~rst & (chk_ok | (ok_vld & ~wr_done));
        ok_addr <= chk_ok ? mem_cmd.addr : ok_addr;
        wrote <= ~rst & busy & (wrote | wr_done);
        last_wr <= wr_done ? mem_cmd.addr : last_wr;
    end
    sequence answer_s;
        avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_bus_answer: assert property (start |-> answer_s)
        else $error("bus answer not in third cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_no_rd_wr: assert property (!(mem_cmd.rd && mem_cmd.wr))
        else $error("read and write together");
    a_req_held: assert property (mem_cmd.rd && !mem_rsp.ack
        |=> mem_cmd.rd && $stable(mem_cmd.addr))
        else $error("read request dropped early");
    a_ack_drop: assert property ((mem_cmd.rd || mem_cmd.wr) && mem_rsp.ack
        |=> !mem_cmd.rd && !mem_cmd.wr)
        else $error("request kept after ack");
    a_wr_checked: assert property (mem_cmd.wr
        |-> ok_vld && mem_cmd.addr == ok_addr)
        else $error("write without cleared check");
    a_deny_stops: assert property (mem_cmd.chk && mem_rsp.chk_ack
        && mem_rsp.chk_deny |=> !mem_cmd.wr [*4])
        else $error("write after refused check");
    a_store_step: assert property ($rose(mem_cmd.wr) && wrote
        |-> mem_cmd.addr == last_wr + 16'h0002)
        else $error("store address did not step by two");
endmodule : hwa_assertions
bind hwa_add_datapath hwa_assertions i_chk (.sys_clk(sys_clk), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mem_cmd(mem_cmd),
    .mem_rsp(mem_rsp), .busy(busy));
`default_nettype wire

// ===== test/hwa_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module hwa_mem_model (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire hwa_pkg::hwa_mem_cmd_type mem_cmd, // request
    output var hwa_pkg::hwa_mem_rsp_type mem_rsp, // answer
    input wire logic [15:0] deny_addr, // refused store address
    input wire logic [1:0] lat // wait before answering
);
    logic [15:0] mem [0:255];
    logic [1:0] cnt;
    wire idle = ~mem_rsp.ack & ~mem_rsp.chk_ack;
    wire due = idle & (cnt == lat);
    // data and deny lines wander outside the answer cycle
    always @(posedge sys_clk) begin
        mem_rsp.ack <= 1'b0;
        mem_rsp.chk_ack <= 1'b0;
        mem_rsp.chk_deny <= ~mem_rsp.chk_deny;
        mem_rsp.rdata <= ~mem_rsp.rdata;
        cnt <= 2'h0;
        if (rst) begin
            mem_rsp <= '0;
        end else if ((mem_cmd.rd | mem_cmd.wr | mem_cmd.chk) & idle & ~due) begin
            cnt <= cnt + 2'h1;
        end else if (due & mem_cmd.chk) begin
            mem_rsp.chk_ack <= 1'b1;
            mem_rsp.chk_deny <= mem_cmd.addr == deny_addr;
        end else if (due & (mem_cmd.rd | mem_cmd.wr)) begin
            mem_rsp.ack <= 1'b1;
            mem_rsp.rdata <= mem[mem_cmd.addr[8:1]];
            if (mem_cmd.wr) begin
                mem[mem_cmd.addr[8:1]] <= mem_cmd.wdata;
            end
        end
    end
endmodule : hwa_mem_model
`default_nettype wire

// ===== test/hwa_add_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hwa_add_datapath_tb;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, busy;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    hwa_pkg::hwa_mem_cmd_type mem_cmd;
    hwa_pkg::hwa_mem_rsp_type mem_rsp;
    logic [15:0] deny_addr;
    logic [1:0] lat;
    int errors = 0;
    int comparisons = 0;
    hwa_add_datapath i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .busy(busy));
    hwa_mem_model i_mem (.sys_clk(sys_clk), .rst(rst), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp),
        .deny_addr(deny_addr), .lat(lat));
    task automatic close_out;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic setr(input logic [3:0] i, input logic [15:0] v);
        bus(1'b1, hwa_pkg::ADDR_GPR_SEL, {28'h0, i});
        bus(1'b1, hwa_pkg::ADDR_GPR_DATA, {16'h0, v});
    endtask : setr
    task automatic getr(input logic [3:0] i, input logic [15:0] e);
        bus(1'b1, hwa_pkg::ADDR_GPR_SEL, {28'h0, i});
        bus(1'b0, hwa_pkg::ADDR_GPR_DATA, 32'h0);
        chk("gpr", {16'h0, e}, q);
    endtask : getr
    task automatic chk_cond(input logic [3:0] e);
        bus(1'b0, hwa_pkg::ADDR_PROG_STATUS, 32'h0);
        chk("condition code", {28'h0, e}, q);
    endtask : chk_cond
    task automatic run(input logic [2:0] op, input logic [3:0] first, input logic [3:0] f2);
        bus(1'b1, hwa_pkg::ADDR_CMD, {1'b1, 19'h0, f2, first, 1'b0, op});
        @(posedge sys_clk);
        chk("busy", 32'h1, {31'h0, busy});
        do bus(1'b0, hwa_pkg::ADDR_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask : run
    task automatic t_short;
        chk_cond(4'h0);
        bus(1'b0, 5'h1c, 32'h0);
        chk("unmapped", 32'h0, q);
        setr(4'h1, 16'hfffe);
        run(3'h0, 4'h1, 4'hf);
        getr(4'h1, 16'h000d);
        chk_cond(4'ha);
    endtask : t_short
    task automatic t_regreg;
        setr(4'h2, 16'h7fff);
        setr(4'h3, 16'h0001);
        run(3'h1, 4'h2, 4'h3);
        getr(4'h2, 16'h8000);
        getr(4'h3, 16'h0001);
        chk_cond(4'h5);
        setr(4'h4, 16'hffff);
        setr(4'h5, 16'h0001);
        run(3'h1, 4'h4, 4'h5);
        getr(4'h4, 16'h0000);
        chk_cond(4'h8);
    endtask : t_regreg
    task automatic t_chain;
        setr(4'ha, 16'h0005);
        setr(4'hb, 16'h0000);
        run(3'h1, 4'ha, 4'hb);
        chk_cond(4'h2);
        setr(4'hc, 16'h0000);
        setr(4'hd, 16'h0000);
        run(3'h5, 4'hc, 4'hd);
        getr(4'hc, 16'h0000);
        chk_cond(4'h2);
        setr(4'h6, 16'hffff);
        setr(4'h7, 16'h0001);
        run(3'h1, 4'h6, 4'h7);
        setr(4'h8, 16'h0000);
        setr(4'h9, 16'h0000);
        run(3'h5, 4'h8, 4'h9);
        getr(4'h8, 16'h0001);
        run(3'h5, 4'h8, 4'h9);
        getr(4'h8, 16'h0001);
        chk_cond(4'h2);
    endtask : t_chain
    task automatic t_memops;
        lat <= 2'h2;
        setr(4'h0, 16'h0004);
        bus(1'b1, hwa_pkg::ADDR_AFIELD, 32'h10);
        i_mem.mem[8'h0a] = 16'h1234;
        setr(4'h1, 16'h0100);
        run(3'h2, 4'h1, 4'h0);
        getr(4'h1, 16'h1334);
        bus(1'b1, hwa_pkg::ADDR_PROG_STATUS, 32'h8);
        run(3'h6, 4'h1, 4'h0);
        getr(4'h1, 16'h2569);
        chk("mem", 32'h1234, {16'h0, i_mem.mem[8'h0a]});
        run(3'h3, 4'h1, 4'h0);
        getr(4'h1, 16'h257d);
        run(3'h4, 4'h1, 4'h0);
        chk("mem", 32'h37b1, {16'h0, i_mem.mem[8'h0a]});
        getr(4'h1, 16'h257d);
    endtask : t_memops
    task automatic t_store;
        lat <= 2'h0;
        bus(1'b1, hwa_pkg::ADDR_AFIELD, 32'h40);
        setr(4'hd, 16'ha001);
        setr(4'he, 16'ha002);
        setr(4'hf, 16'ha003);
        i_mem.mem[8'h25] = 16'h5555;
        run(3'h7, 4'hd, 4'h0);
        chk("mem", 32'ha001, {16'h0, i_mem.mem[8'h22]});
        chk("mem", 32'ha002, {16'h0, i_mem.mem[8'h23]});
        chk("mem", 32'ha003, {16'h0, i_mem.mem[8'h24]});
        chk("mem", 32'h5555, {16'h0, i_mem.mem[8'h25]});
        deny_addr <= 16'h0046;
        setr(4'hd, 16'hb001);
        setr(4'he, 16'hb002);
        run(3'h7, 4'hd, 4'h0);
        chk("mem", 32'hb001, {16'h0, i_mem.mem[8'h22]});
        chk("mem", 32'ha002, {16'h0, i_mem.mem[8'h23]});
        chk("mem", 32'ha003, {16'h0, i_mem.mem[8'h24]});
        bus(1'b0, hwa_pkg::ADDR_STATUS, 32'h0);
        chk("fault", 32'h1, {31'h0, q[1]});
        bus(1'b1, hwa_pkg::ADDR_STATUS, 32'h2);
        bus(1'b0, hwa_pkg::ADDR_STATUS, 32'h0);
        chk("fault", 32'h0, {31'h0, q[1]});
        deny_addr <= 16'h0044;
        run(3'h4, 4'h1, 4'h0);
        chk("mem", 32'hb001, {16'h0, i_mem.mem[8'h22]});
        getr(4'h1, 16'h257d);
        bus(1'b0, hwa_pkg::ADDR_STATUS, 32'h0);
        chk("fault", 32'h1, {31'h0, q[1]});
        chk_cond(4'h1);
    endtask : t_store
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        deny_addr = 16'hffff;
        lat = 2'h0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_short;
        t_regreg;
        t_chain;
        t_memops;
        t_store;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        close_out;
    end
endmodule : hwa_add_datapath_tb
`default_nettype wire
